// >>> hdl/acs_pkg.sv
// Shared constants, types and arithmetic for the conversion sequencer.
// Assumes one 125 MHz clock domain and byte-wide register access.
`default_nettype none
package acs_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NCELL = 6;
  localparam int NAUX  = 21;
  // ------------------------------------------------------------
  // Register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_CELLEN = 8'h02;
  localparam logic [7:0] ADDR_AUXEN0 = 8'h03;
  localparam logic [7:0] ADDR_AUXEN1 = 8'h04;
  localparam logic [7:0] ADDR_AUXEN2 = 8'h05;
  localparam logic [7:0] ADDR_DIAG   = 8'h06;
  localparam logic [7:0] RES_BASE    = 8'h40;
  localparam int CMD_CELL_GO = 0;
  localparam int CMD_AUX_GO  = 1;
  localparam int DIAG_FILT   = 0;
  // Result words: byte address = RES_BASE + 4*word + lane
  localparam logic [5:0] W_CELL_COR = 6'h00;
  localparam logic [5:0] W_CELL_RAW = 6'h06;
  localparam logic [5:0] W_DIE      = 6'h0c;
  localparam logic [5:0] W_AUX      = 6'h10;
  localparam logic [5:0] W_RAW24    = 6'h25;
  localparam logic [5:0] W_LAST     = 6'h26;
  localparam logic [4:0] M_GPIO1_RAW = 5'h15;
  localparam logic [4:0] M_BAT_RAW   = 5'h16;
  // Aux round-robin positions
  localparam logic [4:0] CH_CELL  = 5'h00;
  localparam logic [4:0] CH_BAT   = 5'h01;
  localparam logic [4:0] CH_GPIO1 = 5'h05;
  // ------------------------------------------------------------
  // Reset values, presets, scaling
  // ------------------------------------------------------------
  localparam logic [5:0]  CELLEN_RST = 6'h00;
  localparam logic [20:0] AUXEN_RST  = 21'h00000;
  localparam logic [23:0] PRESET16   = 24'h008000;
  localparam logic [23:0] PRESET24   = 24'h800000;
  localparam int TEMP_SHIFT = 4;
  // Count weights, for software only
  localparam real DIE_LSB_C     = 0.02553;
  localparam real BAT_LSB_MV    = 2.827;
  localparam real AVDD_LSB_UV   = 381.622;
  localparam real COR_LSB_UV    = 190.7349;
  localparam real GPIO1U_LSB_UV = 0.745;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    AUX_IDLE = 2'b00,
    AUX_SEEK = 2'b01,
    AUX_CONV = 2'b10,
    AUX_RAW  = 2'b11
  } acs_aux_state_t;
  typedef struct packed {
    logic [NCELL-1:0]       done;
    logic [NCELL-1:0][23:0] raw;
  } acs_cell_in_t;
  typedef struct packed {
    logic        done;
    logic [15:0] raw;
  } acs_die_in_t;
  typedef struct packed {
    logic        done;
    logic [23:0] raw;
    logic [23:0] filt_raw;
  } acs_aux_in_t;
  typedef struct packed {
    logic [NCELL-1:0] cell_start;
    logic             die_start;
    logic             aux_start;
    logic [4:0]       aux_chan;
  } acs_conv_ctl_t;
  // Temperature correction of a raw reading by the stored die value
  function automatic logic [15:0] acs_correct(input logic [23:0] raw,
                                              input logic [15:0] temp);
    logic [15:0] adj;
    adj = 16'($signed(temp) >>> TEMP_SHIFT);
    return 16'(raw[23:8] - adj);
  endfunction
endpackage
`default_nettype wire

// >>> hdl/acs_result_mem.sv
// Result store with byte read port and high-byte snapshot lock.
// Assumes the read data are wanted exactly one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module acs_result_mem #(
  parameter int DW    = 24,
  parameter int AW    = 5,
  parameter int DEPTH = 32
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  input  wire logic [5:0]    key,
  input  wire logic [1:0]    lane,
  input  wire logic          lock,
  input  wire logic          ext_sel,
  input  wire logic [DW-1:0] ext_word,
  input  wire logic          valid,
  input  wire logic [DW-1:0] preset,
  output logic      [7:0]    q
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] word;
  logic [DW-1:0] snap_reg;
  logic [5:0]    snap_key_reg;
  logic          snap_ok_reg;

  function automatic logic [7:0] pick(input logic [DW-1:0] w,
                                      input logic [1:0] l);
    logic [31:0] x;
    x = 32'(w);
    return x[8*l +: 8];
  endfunction

  // Storage, no reset: unwritten words are masked by valid
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Live word, with diagnostic pattern until written
  always_comb
  begin
    word = ext_sel ? ext_word : (valid ? mem[raddr] : preset);
  end

  // Snapshot taken on a high-byte read
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      snap_reg     <= '0;
      snap_key_reg <= 6'h00;
      snap_ok_reg  <= 1'b0;
    end
    else if (re && lock)
    begin
      snap_reg     <= word;
      snap_key_reg <= key;
      snap_ok_reg  <= 1'b1;
    end
  end

  // Registered read byte; lower bytes come from the snapshot when the last high-byte read was of the same word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= 8'h00;
    else if (!re)
      q <= 8'h00;
    else if (!lock && snap_ok_reg && snap_key_reg == key)
      q <= pick(snap_reg, lane);
    else
      q <= pick(word, lane);
  end
endmodule // acs_result_mem
`default_nettype wire

// >>> hdl/acs_sequencer.sv
// Cell, die temperature and auxiliary conversion sequencing.
// Assumes external converters that answer a start with one done pulse.
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [7:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [7:0]            rdata,
  input  wire acs_pkg::acs_cell_in_t cell_in,
  input  wire acs_pkg::acs_die_in_t  die_in,
  input  wire acs_pkg::acs_aux_in_t  aux_in,
  output acs_pkg::acs_conv_ctl_t     ctl
);
  localparam int NC = acs_pkg::NCELL;

  logic [NC-1:0]        cell_en_reg;
  logic [20:0]          aux_en_reg;
  logic                 filt_sel_reg;
  logic [NC-1:0]        cell_run_reg;
  logic [NC-1:0]        cell_valid_reg;
  logic [NC-1:0]        go_mask_reg;
  logic                 die_run_reg;
  logic                 die_valid_reg;
  logic                 cell_act_reg;
  logic                 cell_rdy_reg;
  logic [15:0]          die_temp_reg;
  logic [NC-1:0][23:0]  cell_raw_reg;
  logic [NC-1:0][15:0]  cell_cor_reg;
  acs_pkg::acs_aux_state_t aux_state_reg;
  logic [4:0]           aux_ptr_reg;
  logic [4:0]           aux_chan_reg;
  logic                 aux_act_reg;
  logic                 aux_rdy_reg;
  logic [22:0]          aux_valid_reg;
  logic [23:0]          raw_hold_reg;
  logic                 go_cell;
  logic                 go_aux;
  logic [NC-1:0]        cell_fin;
  logic                 die_fin;
  logic                 cell_busy_next;
  logic [5:0]           nx;
  logic                 aux_raw_ch;
  logic [4:0]           raw_idx;
  logic [15:0]          aux_cor;
  logic                 mem_we;
  logic [4:0]           mem_waddr;
  logic [23:0]          mem_wdata;
  logic [7:0]           off;
  logic [5:0]           rword;
  logic [4:0]           mi;
  logic [1:0]           rlane;
  logic                 rlock;
  logic                 ext_sel;
  logic [23:0]          ext_word;
  logic                 rvalid;
  logic [23:0]          rpreset;
  logic [7:0]           reg_byte;

  // First enabled aux channel at or above a position; bit 5 = none
  function automatic logic [5:0] next_en(input logic [20:0] m,
                                         input logic [4:0] from);
    logic [5:0] r;
    r = 6'h20;
    for (int i = 20; i >= 0; i--)
      if (m[i] && 5'(i) >= from)
        r = {1'b0, 5'(i)};
    return r;
  endfunction

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  always_comb
  begin
    go_cell = wr && addr == acs_pkg::ADDR_CMD
              && wdata[acs_pkg::CMD_CELL_GO];
    go_aux  = wr && addr == acs_pkg::ADDR_CMD
              && wdata[acs_pkg::CMD_AUX_GO];
  end

  // Enables and diagnostic control; settling is the host's job
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cell_en_reg  <= acs_pkg::CELLEN_RST;
      aux_en_reg   <= acs_pkg::AUXEN_RST;
      filt_sel_reg <= 1'b0;
    end
    else if (wr)
    begin
      case (addr)
        acs_pkg::ADDR_CELLEN: cell_en_reg <= wdata[NC-1:0];
        acs_pkg::ADDR_AUXEN0: aux_en_reg[7:0] <= wdata;
        acs_pkg::ADDR_AUXEN1: aux_en_reg[15:8] <= wdata;
        acs_pkg::ADDR_AUXEN2: aux_en_reg[20:16] <= wdata[4:0];
        acs_pkg::ADDR_DIAG:   filt_sel_reg <= wdata[acs_pkg::DIAG_FILT];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Cell and die converters
  // ------------------------------------------------------------
  // A done beside a start pulse belongs to the aborted run
  always_comb
  begin
    cell_fin       = cell_run_reg & cell_in.done & ~ctl.cell_start;
    die_fin        = die_run_reg && die_in.done && !ctl.die_start;
    cell_busy_next = |(cell_run_reg & ~cell_fin)
                     || (die_run_reg && !die_fin);
  end

  // Run, valid and flag tracking; a start wins over any done
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cell_run_reg   <= '0;
      cell_valid_reg <= '0;
      go_mask_reg    <= '0;
      die_run_reg    <= 1'b0;
      die_valid_reg  <= 1'b0;
      cell_act_reg   <= 1'b0;
      cell_rdy_reg   <= 1'b0;
    end
    else if (go_cell)
    begin
      cell_run_reg   <= cell_en_reg;
      go_mask_reg    <= cell_en_reg;
      die_run_reg    <= 1'b1;
      cell_valid_reg <= '0;
      die_valid_reg  <= 1'b0;
      cell_act_reg   <= 1'b1;
      cell_rdy_reg   <= 1'b0;
    end
    else
    begin
      cell_run_reg   <= cell_run_reg & ~cell_fin;
      cell_valid_reg <= cell_valid_reg | cell_fin;
      die_run_reg    <= die_run_reg && !die_fin;
      if (die_fin)
        die_valid_reg <= 1'b1;
      cell_act_reg   <= cell_busy_next;
      if (cell_act_reg && !cell_busy_next)
        cell_rdy_reg <= 1'b1;
    end
  end

  // Per-channel results, written as each converter finishes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cell_raw_reg <= '0;
      cell_cor_reg <= '0;
      die_temp_reg <= 16'h0000;
    end
    else if (!go_cell)
    begin
      for (int i = 0; i < NC; i++)
        if (cell_fin[i])
        begin
          cell_raw_reg[i] <= cell_in.raw[i];
          cell_cor_reg[i] <= acs_pkg::acs_correct(cell_in.raw[i],
                                                  die_temp_reg);
        end
      if (die_fin)
        die_temp_reg <= die_in.raw;
    end
  end

  // ------------------------------------------------------------
  // Auxiliary round-robin
  // ------------------------------------------------------------
  always_comb
  begin
    nx         = next_en(aux_en_reg, aux_ptr_reg);
    aux_raw_ch = aux_chan_reg == acs_pkg::CH_GPIO1
                 || aux_chan_reg == acs_pkg::CH_BAT;
    raw_idx    = aux_chan_reg == acs_pkg::CH_GPIO1 ?
                 acs_pkg::M_GPIO1_RAW : acs_pkg::M_BAT_RAW;
    // Stale temperature if no cell pass ran alongside
    aux_cor    = acs_pkg::acs_correct(aux_in.raw, die_temp_reg);
    if (aux_chan_reg == acs_pkg::CH_CELL)
      aux_cor = {aux_cor[15], aux_cor[15:1]};
  end

  // Pass control; a start at any point restarts from the top
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      aux_state_reg <= acs_pkg::AUX_IDLE;
      aux_ptr_reg   <= 5'h00;
      aux_chan_reg  <= 5'h00;
      aux_act_reg   <= 1'b0;
      aux_rdy_reg   <= 1'b0;
      aux_valid_reg <= '0;
      raw_hold_reg  <= 24'h000000;
    end
    else if (go_aux)
    begin
      aux_state_reg <= acs_pkg::AUX_SEEK;
      aux_ptr_reg   <= 5'h00;
      aux_act_reg   <= 1'b1;
      aux_rdy_reg   <= 1'b0;
      aux_valid_reg <= '0;
    end
    else
    begin
      case (aux_state_reg)
        acs_pkg::AUX_IDLE: ;
        acs_pkg::AUX_SEEK:
          if (nx[5])
          begin
            aux_state_reg <= acs_pkg::AUX_IDLE;
            aux_act_reg   <= 1'b0;
            aux_rdy_reg   <= 1'b1;
          end
          else
          begin
            aux_chan_reg  <= nx[4:0];
            aux_state_reg <= acs_pkg::AUX_CONV;
          end
        acs_pkg::AUX_CONV:
          if (aux_in.done && !ctl.aux_start)
          begin
            aux_valid_reg[aux_chan_reg] <= 1'b1;
            raw_hold_reg <= (aux_chan_reg == acs_pkg::CH_GPIO1
                             && filt_sel_reg) ?
                            aux_in.filt_raw : aux_in.raw;
            if (aux_raw_ch)
              aux_state_reg <= acs_pkg::AUX_RAW;
            else
            begin
              aux_ptr_reg   <= aux_chan_reg + 5'h01;
              aux_state_reg <= acs_pkg::AUX_SEEK;
            end
          end
        acs_pkg::AUX_RAW:
        begin
          aux_valid_reg[raw_idx] <= 1'b1;
          aux_ptr_reg   <= aux_chan_reg + 5'h01;
          aux_state_reg <= acs_pkg::AUX_SEEK;
        end
        default: aux_state_reg <= acs_pkg::AUX_IDLE;
      endcase
    end
  end

  // Converter start pulses, all from flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ctl <= '0;
    else
    begin
      ctl.cell_start <= go_cell ? cell_en_reg : '0;
      ctl.die_start  <= go_cell;
      ctl.aux_start  <= !go_aux && aux_state_reg == acs_pkg::AUX_SEEK
                        && !nx[5];
      if (!go_aux && aux_state_reg == acs_pkg::AUX_SEEK && !nx[5])
        ctl.aux_chan <= nx[4:0];
    end
  end

  // ------------------------------------------------------------
  // Result storage and register reads
  // ------------------------------------------------------------
  always_comb
  begin
    mem_we    = !go_aux && ((aux_state_reg == acs_pkg::AUX_CONV
                             && aux_in.done && !ctl.aux_start)
                            || aux_state_reg == acs_pkg::AUX_RAW);
    mem_waddr = aux_state_reg == acs_pkg::AUX_RAW ? raw_idx : aux_chan_reg;
    mem_wdata = aux_state_reg == acs_pkg::AUX_RAW ?
                raw_hold_reg : {8'h00, aux_cor};
  end

  // Control-space byte
  always_comb
  begin
    case (addr)
      acs_pkg::ADDR_STATUS: reg_byte = {4'h0, aux_rdy_reg, cell_rdy_reg,
                                        aux_act_reg, cell_act_reg};
      acs_pkg::ADDR_CELLEN: reg_byte = 8'(cell_en_reg);
      acs_pkg::ADDR_AUXEN0: reg_byte = aux_en_reg[7:0];
      acs_pkg::ADDR_AUXEN1: reg_byte = aux_en_reg[15:8];
      acs_pkg::ADDR_AUXEN2: reg_byte = {3'h0, aux_en_reg[20:16]};
      acs_pkg::ADDR_DIAG:   reg_byte = {7'h00, filt_sel_reg};
      default:              reg_byte = 8'h00;
    endcase
  end

  // Result-space decode; unmapped reads return zero
  always_comb
  begin
    off      = addr - acs_pkg::RES_BASE;
    rword    = off[7:2];
    mi       = 5'(rword - acs_pkg::W_AUX);
    rlane    = off[1:0];
    ext_sel  = 1'b1;
    ext_word = 24'h000000;
    rvalid   = 1'b0;
    rpreset  = acs_pkg::PRESET16;
    rlock    = 1'b0;
    if (addr < acs_pkg::RES_BASE)
    begin
      rlane    = 2'h0;
      ext_word = {16'h0000, reg_byte};
    end
    else if (rword < acs_pkg::W_CELL_RAW)
    begin
      ext_word = cell_valid_reg[rword[2:0]] ?
                 {8'h00, cell_cor_reg[rword[2:0]]} :
                 acs_pkg::PRESET16;
      rlock    = rlane == 2'h1;
    end
    else if (rword < acs_pkg::W_DIE)
    begin
      ext_word = cell_valid_reg[3'(rword - acs_pkg::W_CELL_RAW)] ?
                 cell_raw_reg[3'(rword - acs_pkg::W_CELL_RAW)] :
                 acs_pkg::PRESET24;
      rlock    = rlane == 2'h2;
    end
    else if (rword == acs_pkg::W_DIE)
    begin
      ext_word = die_valid_reg ? {8'h00, die_temp_reg} :
                 acs_pkg::PRESET16;
      rlock    = rlane == 2'h1;
    end
    else if (rword >= acs_pkg::W_AUX && rword <= acs_pkg::W_LAST)
    begin
      ext_sel = 1'b0;
      rvalid  = aux_valid_reg[mi];
      if (rword >= acs_pkg::W_RAW24)
      begin
        rpreset = acs_pkg::PRESET24;
        rlock   = rlane == 2'h2;
      end
      else
        rlock = rlane == 2'h1;
    end
  end

  acs_result_mem #(
    .DW    (24),
    .AW    (5),
    .DEPTH (32)
  ) u_mem (
    .clk      (clk),
    .reset    (reset),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .re       (rd),
    .raddr    (mi),
    .key      (rword),
    .lane     (rlane),
    .lock     (rlock),
    .ext_sel  (ext_sel),
    .ext_word (ext_word),
    .valid    (rvalid),
    .preset   (rpreset),
    .q        (rdata)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_cell_start;
    @(posedge clk) disable iff (reset)
    go_cell |=> ctl.cell_start == $past(cell_en_reg) && ctl.die_start;
  endproperty
  a_cell_start: assert property (p_cell_start)
    else $error("cell start pulse does not match enables");

  property p_cell_store;
    @(posedge clk) disable iff (reset)
    (cell_fin[0] && !go_cell) |=> cell_valid_reg[0]
      && cell_raw_reg[0] == $past(cell_in.raw[0]);
  endproperty
  a_cell_store: assert property (p_cell_store)
    else $error("finished cell result not stored");

  property p_cell_ready;
    @(posedge clk) disable iff (reset)
    $rose(cell_rdy_reg) |-> !cell_act_reg && cell_run_reg == '0
      && (cell_valid_reg & go_mask_reg) == go_mask_reg;
  endproperty
  a_cell_ready: assert property (p_cell_ready)
    else $error("cell ready before results stored");

  property p_preset;
    @(posedge clk) disable iff (reset)
    go_cell |=> cell_valid_reg == '0 && !die_valid_reg;
  endproperty
  a_preset: assert property (p_preset)
    else $error("start did not preset cell results");

  property p_rdy_clear;
    @(posedge clk) disable iff (reset)
    (go_cell || go_aux) |=> !(($past(go_cell) && cell_rdy_reg)
      || ($past(go_aux) && aux_rdy_reg));
  endproperty
  a_rdy_clear: assert property (p_rdy_clear)
    else $error("ready flag not cleared by start");

  property p_aux_restart;
    @(posedge clk) disable iff (reset)
    go_aux |=> aux_state_reg == acs_pkg::AUX_SEEK
      && aux_ptr_reg == 5'h00 && aux_valid_reg == '0 ##1 !ctl.aux_start
      || ctl.aux_chan == $past(nx[4:0]);
  endproperty
  a_aux_restart: assert property (p_aux_restart)
    else $error("aux start did not restart the pass");

  property p_aux_single;
    @(posedge clk) disable iff (reset)
    (aux_state_reg == acs_pkg::AUX_SEEK && nx[5] && !go_aux)
      |=> aux_state_reg == acs_pkg::AUX_IDLE ##1
          (aux_state_reg == acs_pkg::AUX_IDLE || $past(go_aux));
  endproperty
  a_aux_single: assert property (p_aux_single)
    else $error("aux pass did not stop");

  property p_aux_ready;
    @(posedge clk) disable iff (reset)
    $rose(aux_rdy_reg) |-> !aux_act_reg
      && aux_state_reg == acs_pkg::AUX_IDLE;
  endproperty
  a_aux_ready: assert property (p_aux_ready)
    else $error("aux ready while converter active");
endmodule // acs_sequencer
`default_nettype wire

// >>> tb/acs_conv_model.sv
// Converter model: answers each start not cut short by a new start with one done pulse and a result.
// Assumes start pulses come one cycle long from the sequencer ctl port.
`timescale 1ns/1ns
`default_nettype none
module acs_conv_model (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [23:0]            val,
  input  wire acs_pkg::acs_conv_ctl_t ctl,
  output acs_pkg::acs_cell_in_t       cell_in,
  output acs_pkg::acs_die_in_t        die_in,
  output acs_pkg::acs_aux_in_t        aux_in
);
  int         cnt [8];
  wire logic [7:0] st;
  assign st = {ctl.aux_start, ctl.die_start, ctl.cell_start};
  // Cycles left per converter; a new start restarts it like the real one
  always_ff @(posedge clk or posedge reset)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (reset)
        cnt[i] <= 0;
      else if (st[i])
        cnt[i] <= i < 6 ? 4 + 2 * i : i == 6 ? 3 : 6;
      else if (cnt[i] > 0)
        cnt[i] <= cnt[i] - 1;
    end
  end
  // Results only with done, otherwise inverted so stale data never match; filt_raw is the reverse, ~val with done
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      cell_in.done[i] = cnt[i] == 1;
      cell_in.raw[i] = cell_in.done[i] ? val ^ 24'(i) : ~val;
    end
    die_in.done = cnt[6] == 1;
    die_in.raw = die_in.done ? val[15:0] : ~val[15:0];
    aux_in.done = cnt[7] == 1;
    aux_in.raw = aux_in.done ? val + 24'(ctl.aux_chan) : ~val;
    aux_in.filt_raw = aux_in.done ? ~val : val;
  end
endmodule // acs_conv_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench: host tasks on the register port, converter model.
// Assumes the register map and result word layout of acs_pkg.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  logic [7:0]             addr = 8'h00;
  logic [7:0]             wdata = 8'h00;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic                   rd_d = 1'b0;
  logic                   pol = 1'b0;
  logic [7:0]             rdata;
  logic [23:0]            val = 24'h000000;
  logic [31:0]            seed = 32'hdb9a7c33;
  logic [23:0]            v;
  logic [23:0]            g;
  logic [15:0]            t;
  logic [15:0]            c;
  logic [7:0]             e8;
  logic [4:0]             e5;
  int                     n_mismatch = 0;
  int                     checked = 0;
  logic [7:0]             q[$];
  logic [4:0]             chq[$];
  acs_pkg::acs_cell_in_t  cell_in;
  acs_pkg::acs_die_in_t   die_in;
  acs_pkg::acs_aux_in_t   aux_in;
  acs_pkg::acs_conv_ctl_t ctl;
  acs_sequencer acs_sequencer_i (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cell_in(cell_in),
    .die_in(die_in), .aux_in(aux_in), .ctl(ctl));
  acs_conv_model acs_conv_model_i (.clk(clk), .reset(reset), .val(val),
    .ctl(ctl), .cell_in(cell_in), .die_in(die_in), .aux_in(aux_in));
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(d);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Status poll, bounded; polled reads bypass the expectation queue
  task automatic wait_rdy(input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 100 && s[b] !== 1'b1; k++)
    begin
      @(posedge clk);
      addr <= acs_pkg::ADDR_STATUS;
      rd <= 1'b1;
      pol <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 s = rdata;
      pol = 1'b0;
    end
    `CHK("ready flag", 1'b1, s[b])
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Oldest note against read data and aux channel at each start
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      e8 = q.pop_front();
      `CHK("rdata", e8, rdata)
    end
    if (ctl.aux_start === 1'b1)
    begin
      e5 = chq.pop_front();
      `CHK("aux_chan", e5, ctl.aux_chan)
    end
    rd_d <= rd & ~pol;
  end
  // Hang guard, well past the expected run
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd_chk(acs_pkg::ADDR_STATUS, 8'h00);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h41, 8'h80);
    $display("test reset done");
    v = 24'(rnd());
    t = v[15:0];
    val <= v;
    wr_reg(acs_pkg::ADDR_CELLEN, 8'h3f);
    repeat (8) @(posedge clk);
    wr_reg(acs_pkg::ADDR_CMD, 8'h01);
    repeat (6) @(posedge clk);
    wr_reg(acs_pkg::ADDR_CMD, 8'h01);
    rd_chk(8'h41, 8'h80);
    rd_chk(acs_pkg::ADDR_STATUS, 8'h01);
    wait_rdy(2);
    rd_chk(acs_pkg::ADDR_STATUS, 8'h04);
    for (int i = 0; i < 6; i++)
      for (int b = 2; b >= 0; b--)
        rd_chk(8'h58 + 8'(4 * i + b), 8'((v ^ 24'(i)) >> (8 * b)));
    rd_chk(8'h71, t[15:8]);
    rd_chk(8'h70, t[7:0]);
    c = v[23:8] - 16'($signed(t) >>> acs_pkg::TEMP_SHIFT);
    rd_chk(8'h41, c[15:8]);
    rd_chk(8'h40, c[7:0]);
    $display("test cell done");
    for (int f = 0; f < 2; f++)
    begin
      v = 24'(rnd());
      val <= v;
      wr_reg(acs_pkg::ADDR_DIAG, 8'(f));
      wr_reg(acs_pkg::ADDR_AUXEN0, 8'h22);
      wr_reg(acs_pkg::ADDR_AUXEN2, 8'h10);
      wr_reg(acs_pkg::ADDR_AUXEN1, 8'h00);
      rd_chk(acs_pkg::ADDR_AUXEN0, 8'h22);
      if (f == 1)
        chq.push_back(5'h01);
      chq.push_back(5'h01);
      chq.push_back(5'h05);
      chq.push_back(5'h14);
      // Second pass also runs the cells for a fresh die temperature
      if (f == 1)
        t = v[15:0];
      wr_reg(acs_pkg::ADDR_CMD, f == 1 ? 8'h03 : 8'h02);
      if (f == 1)
      begin
        repeat (2) @(posedge clk);
        wr_reg(acs_pkg::ADDR_CMD, 8'h02);
      end
      wait_rdy(3);
      rd_chk(acs_pkg::ADDR_STATUS, 8'h0c);
      c = 16'((v + 24'h1) >> 8) - 16'($signed(t) >>> acs_pkg::TEMP_SHIFT);
      rd_chk(8'h85, c[15:8]);
      rd_chk(8'h84, c[7:0]);
      g = f == 1 ? ~v : v + 24'h5;
      for (int b = 2; b >= 0; b--)
        rd_chk(8'hd4 + 8'(b), 8'(g >> (8 * b)));
      rd_chk(8'h89, 8'h80);
      $display("test aux pass %0d done", f);
    end
    // Let the last read be compared before the count
    repeat (3) @(posedge clk);
    `CHK("notes left", 0, q.size() + chq.size())
    summarize();
  end
endmodule // tb_top
`default_nettype wire
